// file: rtl/sfpm_pkg.sv
/*
  constants, encodings and types for the serial flash pin and space map block.
  assumes a 50 MHz system clock; all link timing is derived from that period.
*/
`default_nettype none

package sfpm_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS        = 20;
  localparam int RESTART_PULSE_MIN_NS = 1000;
  localparam int RESTART_CYC          = (RESTART_PULSE_MIN_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;
  localparam int RST_CNT_W            = 7;
  localparam logic [RST_CNT_W-1:0] RESTART_CNT = RST_CNT_W'(RESTART_CYC);

  // ==========================================================================
  // main array geometry
  localparam int ARRAY_BYTES  = 2097152;
  localparam int BLOCK_COUNT  = 32;
  localparam int SECTOR_COUNT = 512;
  localparam int PAGE_COUNT   = 8192;
  localparam int MEM_ADDR_W   = $clog2(ARRAY_BYTES);
  localparam int ADDR_W       = 24;
  localparam int SECTOR_LSB   = $clog2(ARRAY_BYTES / SECTOR_COUNT);
  localparam int BLOCK_LSB    = $clog2(ARRAY_BYTES / BLOCK_COUNT);
  localparam int PAGE_LSB     = $clog2(ARRAY_BYTES / PAGE_COUNT);

  // ==========================================================================
  // security register windows and parameter space map
  localparam int          SECREG_LSB      = 12;
  localparam logic [7:0]  SFDP_HDR_RSV    = 8'h10;
  localparam logic [7:0]  SFDP_PARAM_BASE = 8'h30;
  localparam logic [7:0]  SFDP_PARAM_END  = 8'h6f;
  localparam logic [7:0]  SFDP_RSV_BASE   = 8'h70;
  localparam logic [31:0] SFDP_SIGNATURE  = 32'h53464450;
  localparam logic [7:0]  SFDP_HDR_FILL   = 8'hff;
  localparam logic [7:0]  SFDP_PARAM_FILL = 8'hff;
  localparam logic [7:0]  SFDP_RSV_FILL   = 8'hff;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_WSTAT    = 8'h01;
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_PROG     = 8'h02;
  localparam logic [7:0] OP_QREAD    = 8'h6b;
  localparam logic [7:0] OP_QPROG    = 8'h32;
  localparam logic [7:0] OP_SERASE   = 8'h20;
  localparam logic [7:0] OP_BERASE   = 8'hd8;
  localparam logic [7:0] OP_CERASE   = 8'hc7;
  localparam logic [7:0] OP_SFDP     = 8'h5a;
  localparam logic [7:0] OP_SR_PROG  = 8'h42;
  localparam logic [7:0] OP_SR_ERASE = 8'h44;
  localparam logic [7:0] OP_SR_READ  = 8'h48;

  // ==========================================================================
  // phase lengths in link bits, pin enables
  localparam logic [4:0] LEN_BYTE  = 5'd8;
  localparam logic [4:0] LEN_ADDR  = 5'd24;
  localparam logic [4:0] LEN_DUMMY = 5'd8;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD   = 4'hf;

  typedef enum logic [2:0] {
    ST_CMD    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_READ   = 3'b011,
    ST_WRITE  = 3'b100,
    ST_WSTAT  = 3'b101,
    ST_IGNORE = 3'b110
  } sfpm_state_e;

  typedef enum logic [1:0] {
    ER_SECTOR = 2'b00,
    ER_BLOCK  = 2'b01,
    ER_CHIP   = 2'b10,
    ER_SECREG = 2'b11
  } sfpm_erase_e;

endpackage

`default_nettype wire

// file: rtl/sfpm_sync.sv
/*
  two flip-flop synchroniser, one chain per bit.
  assumes inputs arrive from outside the clk domain.
*/
`default_nettype none

module sfpm_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================================
  // per-bit chains
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic stable;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= d[i];
          stable <= meta;
        end
      end
      assign q[i] = stable;
    end
  endgenerate

endmodule

`default_nettype wire

// file: rtl/sfpm_core.sv
/*
  flash device pin logic: serial link decode, pause and hardware restart on the
  shared pin, write-protect, main array / security register / parameter space map.
  assumes array storage outside (combinational read on mem_addr/mem_space) and the
  status register outside; link pins arrive asynchronous to clk.
*/
`default_nettype none

module sfpm_core (
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  input  wire logic                            sck,
  input  wire logic                            cs_n,
  input  wire logic [3:0]                      io_in,
  output logic      [3:0]                      io_out,
  output logic      [3:0]                      io_oe,
  input  wire logic                            quad_enable_bit,
  input  wire logic                            pause_restart_select,
  input  wire logic                            status_guard_bit,
  input  wire logic [2:0]                      lock_bits,
  output logic      [sfpm_pkg::MEM_ADDR_W-1:0] mem_addr,
  output logic      [1:0]                      mem_space,
  input  wire logic [7:0]                      mem_rd_data,
  output logic                                 mem_prog,
  output logic      [7:0]                      mem_prog_data,
  output logic                                 mem_erase,
  output sfpm_pkg::sfpm_erase_e                erase_kind,
  output logic                                 status_wr,
  output logic      [7:0]                      status_wr_data,
  output logic                                 status_wr_refused,
  output logic                                 write_enable_latch,
  output logic                                 paused,
  output logic                                 hw_reset_active
);
  import sfpm_pkg::*;

  // ==========================================================================
  // pin capture and shared pin function
  logic [5:0]           pins_s;
  logic                 sck_prev;
  logic                 cs_prev;
  logic                 armed;
  logic [RST_CNT_W-1:0] rst_cnt;

  sfpm_sync #(.WIDTH(6)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({sck, cs_n, io_in}),
    .q      (pins_s)
  );

  wire       sck_s     = pins_s[5];
  wire       cs_n_s    = pins_s[4];
  wire [3:0] io_s      = pins_s[3:0];
  wire       wp_active = !quad_enable_bit && !io_s[2];
  wire       hold_sel  = !quad_enable_bit && !pause_restart_select;
  wire       reset_sel = !quad_enable_bit && pause_restart_select;
  wire       paused_w  = hold_sel && !io_s[3] && !cs_n_s;
  wire       abort     = (rst_cnt == RESTART_CNT);
  wire       live      = armed && !cs_n_s && !paused_w && !abort;
  wire       rise      = sck_s && !sck_prev && live;
  wire       fall      = !sck_s && sck_prev && live;
  wire       cs_rise   = cs_n_s && !cs_prev;
  wire       cs_fall   = !cs_n_s && cs_prev;

  assign paused          = paused_w;
  assign hw_reset_active = abort;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev <= 1'b0;
      cs_prev  <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      cs_prev  <= cs_n_s;
    end
  end

  // a select fall must be seen before the first command after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
    end else if (abort) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      armed <= 1'b1;
    end
  end

  // low time on the restart pin, independent of the other pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt <= '0;
    end else if (reset_sel && !io_s[3]) begin
      if (rst_cnt != RESTART_CNT) begin
        rst_cnt <= rst_cnt + 1'b1;
      end
    end else begin
      rst_cnt <= '0;
    end
  end

  // ==========================================================================
  // command decode
  sfpm_state_e       state;
  logic [4:0]        cnt;
  logic [7:0]        shreg;
  logic [7:0]        opcode;
  logic [ADDR_W-1:0] addr;
  logic              addr_done;
  logic              wel;

  wire quad_in   = (state == ST_WRITE) && (opcode == OP_QPROG);
  wire [4:0] step = quad_in ? 5'd4 : 5'd1;
  wire [7:0] next_in = quad_in ? {shreg[3:0], io_s} : {shreg[6:0], io_s[0]};
  wire [4:0] phase_len = (state == ST_ADDR) ? LEN_ADDR :
                         (state == ST_DUMMY) ? LEN_DUMMY : LEN_BYTE;
  wire last      = ((cnt + step) == phase_len);
  wire op_quad   = quad_enable_bit && (next_in inside {OP_QREAD, OP_QPROG});
  wire op_n_addr = op_quad || (next_in inside {OP_READ, OP_PROG, OP_SERASE, OP_BERASE,
                                               OP_SFDP, OP_SR_PROG, OP_SR_ERASE,
                                               OP_SR_READ});
  wire is_dummy  = opcode inside {OP_SFDP, OP_SR_READ, OP_QREAD};
  wire is_read   = is_dummy || (opcode == OP_READ);
  wire is_prog   = opcode inside {OP_PROG, OP_QPROG, OP_SR_PROG};
  wire is_sec    = opcode inside {OP_SR_PROG, OP_SR_ERASE, OP_SR_READ};
  wire quad_out  = (opcode == OP_QREAD);
  wire mutating  = is_prog || (opcode inside {OP_SERASE, OP_BERASE, OP_CERASE,
                                              OP_SR_ERASE, OP_WSTAT});

  // security window select; register zero holds the parameter space
  wire [1:0] sec_idx    = addr[SECREG_LSB +: 2];
  wire       sec_in_win = (addr[ADDR_W-1:SECREG_LSB+2] == '0);
  wire [3:0] lock_map   = {lock_bits, 1'b1};
  wire       sec_wr_ok  = sec_in_win && !lock_map[sec_idx];
  wire       sfdp_sel   = (opcode == OP_SFDP) || (is_sec && sec_idx == 2'd0);
  wire       wr_allowed = wel && (is_sec ? sec_wr_ok : 1'b1);
  wire       main_strm  = opcode inside {OP_READ, OP_QREAD};
  // reads of the main array run through all of it; pages and windows wrap
  wire [ADDR_W-1:0] next_addr = main_strm ?
      {addr[ADDR_W-1:MEM_ADDR_W], addr[MEM_ADDR_W-1:0] + MEM_ADDR_W'(1)} :
      {addr[ADDR_W-1:PAGE_LSB], addr[PAGE_LSB-1:0] + PAGE_LSB'(1)};

  wire start_read = rise && last && ((state == ST_DUMMY) ||
                    (state == ST_ADDR && is_read && !is_dummy));
  wire wr_fire    = rise && last && (state == ST_WRITE);
  wire st_fire    = rise && last && (state == ST_WSTAT);
  wire guard_blk  = status_guard_bit && wp_active;

  logic fetch_d;
  logic prog_d;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_CMD;
      cnt       <= '0;
      shreg     <= '0;
      opcode    <= '0;
      addr      <= '0;
      addr_done <= 1'b0;
    end else if (abort || cs_n_s) begin
      state     <= ST_CMD;
      cnt       <= '0;
      opcode    <= '0;
      addr_done <= 1'b0;
    end else begin
      // state survives a pause untouched, so the frame resumes
      if (rise && state != ST_READ && state != ST_IGNORE) begin
        cnt <= last ? 5'd0 : cnt + step;
      end
      if (rise) begin
        case (state)
          ST_CMD: begin
            shreg <= next_in;
            if (last) begin
              opcode <= next_in;
              state  <= op_n_addr ? ST_ADDR :
                        (next_in == OP_WSTAT) ? ST_WSTAT : ST_IGNORE;
            end
          end
          ST_ADDR: begin
            addr <= {addr[ADDR_W-2:0], io_s[0]};
            if (last) begin
              addr_done <= 1'b1;
              state     <= is_dummy ? ST_DUMMY : is_read ? ST_READ :
                           is_prog ? ST_WRITE : ST_IGNORE;
            end
          end
          ST_DUMMY: begin
            if (last) begin
              state <= ST_READ;
            end
          end
          ST_WRITE: begin
            shreg <= next_in;
          end
          ST_WSTAT: begin
            shreg <= next_in;
            if (last) begin
              state <= ST_IGNORE;
            end
          end
          default: begin
          end
        endcase
      end
      if (fetch_d || prog_d) begin
        addr <= next_addr;
      end
    end
  end

  // ==========================================================================
  // read data path
  logic       fetch;
  logic [7:0] out_shift;
  logic [3:0] out_cnt;
  logic       drive_on;

  // reserved and undefined parameter bytes read a fixed fill
  function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
    logic [7:0] b;
    b = SFDP_HDR_FILL;
    if (a >= SFDP_RSV_BASE) begin
      b = SFDP_RSV_FILL;
    end else if (a >= SFDP_PARAM_BASE && a <= SFDP_PARAM_END) begin
      b = SFDP_PARAM_FILL;
    end else if (a < 8'h04) begin
      b = SFDP_SIGNATURE[8 * (3 - int'(a[1:0])) +: 8];
    end
    return b;
  endfunction

  wire [3:0] ostep     = quad_out ? 4'd4 : 4'd1;
  wire       out_last  = ((out_cnt + ostep) == 4'd8);
  wire       emit      = fall && (state == ST_READ);
  wire [7:0] read_byte = sfdp_sel ? sfdp_byte(addr[7:0]) : mem_rd_data;

  assign io_oe = (drive_on && !cs_n_s && !paused_w && !abort) ?
                 (quad_out ? OE_QUAD : OE_SINGLE) : 4'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch   <= 1'b0;
      fetch_d <= 1'b0;
    end else begin
      fetch   <= start_read || (emit && out_last);
      fetch_d <= fetch && !abort;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_shift <= '0;
      out_cnt   <= '0;
      io_out    <= '0;
      drive_on  <= 1'b0;
    end else if (cs_n_s || abort) begin
      out_cnt  <= '0;
      drive_on <= 1'b0;
    end else if (emit) begin
      io_out    <= quad_out ? out_shift[7:4] : {2'b00, out_shift[7], 1'b0};
      out_shift <= quad_out ? {out_shift[3:0], 4'h0} : {out_shift[6:0], 1'b0};
      out_cnt   <= out_last ? 4'd0 : out_cnt + ostep;
      drive_on  <= 1'b1;
    end else if (fetch_d) begin
      out_shift <= read_byte;
    end
  end

  // ==========================================================================
  // program path: old byte read, then only cleared bits written
  logic       prog_pend;
  logic [7:0] prog_byte;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_pend     <= 1'b0;
      prog_byte     <= '0;
      prog_d        <= 1'b0;
      mem_prog      <= 1'b0;
      mem_prog_data <= '0;
    end else begin
      prog_pend <= wr_fire && wr_allowed;
      if (wr_fire) begin
        prog_byte <= next_in;
      end
      prog_d   <= prog_pend && !abort;
      mem_prog <= prog_d;
      if (prog_d) begin
        mem_prog_data <= mem_rd_data & prog_byte;
      end
    end
  end

  // ==========================================================================
  // frame end: erase, write-enable latch; status byte decision
  wire cmd_end   = cs_rise && (state == ST_IGNORE);
  wire er_sector = (opcode == OP_SERASE) && addr_done;
  wire er_block  = (opcode == OP_BERASE) && addr_done;
  wire er_chip   = (opcode == OP_CERASE);
  wire er_sec    = (opcode == OP_SR_ERASE) && addr_done && sec_wr_ok;
  wire erase_go  = cmd_end && wel && !abort &&
                   (er_sector || er_block || er_chip || er_sec);
  wire [MEM_ADDR_W-1:0] erase_base =
      er_block  ? {addr[MEM_ADDR_W-1:BLOCK_LSB], BLOCK_LSB'(0)} :
      er_sector ? {addr[MEM_ADDR_W-1:SECTOR_LSB], SECTOR_LSB'(0)} :
      '0;

  assign write_enable_latch = wel;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_erase  <= 1'b0;
      erase_kind <= ER_SECTOR;
      mem_addr   <= '0;
      mem_space  <= 2'b00;
    end else begin
      mem_erase <= erase_go;
      if (erase_go) begin
        erase_kind <= er_block ? ER_BLOCK : er_sector ? ER_SECTOR :
                      er_chip ? ER_CHIP : ER_SECREG;
      end
      mem_addr  <= erase_go ? erase_base : addr[MEM_ADDR_W-1:0];
      mem_space <= is_sec ? sec_idx : 2'b00;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wel <= 1'b0;
    end else if (abort) begin
      wel <= 1'b0;
    end else if (cmd_end && opcode == OP_WREN) begin
      wel <= 1'b1;
    end else if (cs_rise && state != ST_CMD && mutating) begin
      wel <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_wr         <= 1'b0;
      status_wr_refused <= 1'b0;
      status_wr_data    <= '0;
    end else begin
      status_wr         <= st_fire && wel && !guard_blk;
      status_wr_refused <= st_fire && (!wel || guard_blk);
      if (st_fire) begin
        status_wr_data <= next_in;
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_restart_hit;
    $rose(hw_reset_active);
  endsequence

  sequence s_byte_in;
    wr_fire && wr_allowed;
  endsequence

  chk_wp_guard: assert property (
    (st_fire && guard_blk) |=> (status_wr_refused && !status_wr))
    else $error("status write taken while write-protect guard active");

  chk_quad_wp: assert property (
    quad_enable_bit |-> !wp_active)
    else $error("write-protect active in quad mode");

  chk_pause_hiz: assert property (
    paused_w |-> (io_oe == 4'h0 && !rise && !fall))
    else $error("output driven or clock taken while paused");

  chk_pause_sel: assert property (
    (quad_enable_bit || pause_restart_select || cs_n_s) |-> !paused_w)
    else $error("pause active when not selected");

  chk_restart_abort: assert property (
    s_restart_hit |=> (state == ST_CMD && io_oe == 4'h0 && !wel && !armed))
    else $error("restart did not abort the operation");

  chk_restart_quad: assert property (
    quad_enable_bit |=> !hw_reset_active)
    else $error("restart active with quad enabled");

  chk_prog_and: assert property (
    mem_prog |-> ((mem_prog_data & ~$past(mem_rd_data)) == 8'h00))
    else $error("program sets a bit from zero to one");

  chk_prog_timing: assert property (
    s_byte_in ##1 !abort [*2] |=> mem_prog)
    else $error("program pulse not three cycles after byte");

  chk_sector_base: assert property (
    (mem_erase && erase_kind == ER_SECTOR) |-> (mem_addr[SECTOR_LSB-1:0] == '0))
    else $error("sector erase not on a sector base");

  chk_lock_hold: assert property (
    ((mem_prog || mem_erase) && mem_space != 2'b00) |-> !$past(lock_map[mem_space], 2))
    else $error("locked security register modified");

  chk_cs_tristate: assert property (
    cs_n_s |-> (io_oe == 4'h0))
    else $error("pin driven while deselected");

  chk_launch_fall: assert property (
    $changed(io_out) |-> $past(emit))
    else $error("output changed away from a falling edge");

endmodule

`default_nettype wire

// file: bench/sfpm_host.sv
/*
  link host model: drives sck, cs_n and data line 0, samples data line 1.
  assumes the bench calls its tasks from the clk domain, sck period 160 ns.
*/
`default_nettype none
module sfpm_host (
  input  wire logic clk,
  input  wire logic miso,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 1ns;
  // sck stands low outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic start();
    @(posedge clk);
    #1 cs_n = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      #80 sck = 1'b1;
      #70 rx[i] = miso;
      #10;
    end
  endtask
  task automatic stop();
    #80 sck = 1'b0;
    #80 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
  bench for sfpm_core: table of reads, then status guard, erase, pause, restart.
  assumes memory reads return the low address byte xor the space number.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sfpm_pkg::*;
  typedef struct {logic [7:0] op; logic [23:0] a; logic [7:0] e;} sfpm_row_s;
  logic clk = 1'b0, arst_n = 1'b0, wp_n = 1'b1, io3 = 1'b1, qe = 1'b0, sel = 1'b0;
  logic guard = 1'b1, st_wr = 1'b0, st_ref = 1'b0, st_wr_p, st_ref_p, erase_p, hw_rst;
  logic sck, cs_n, mosi, paused, prog_p, wel_o;
  logic [2:0] locks = 3'h0;
  logic [3:0] io_out, io_oe, io_in;
  logic [MEM_ADDR_W-1:0] mem_addr, erase_addr;
  logic [1:0] mem_space;
  logic [7:0] rx, prog_dat, st_dat, pd, pa;
  sfpm_erase_e kind, ek;
  int fails = 0;
  int n_compared = 0;
  int n_prog = 0;
  sfpm_row_s rows[10] = '{'{OP_READ, 24'h1ff0a5, 8'ha5}, '{OP_SFDP, 24'h0, 8'h53},
    '{OP_SFDP, 24'h3, 8'h50}, '{OP_SFDP, 24'h10, 8'hff}, '{OP_SFDP, 24'h30, 8'hff},
    '{OP_SFDP, 24'h6f, 8'hff}, '{OP_SFDP, 24'h70, 8'hff}, '{OP_SFDP, 24'hff, 8'hff},
    '{OP_SR_READ, 24'h001010, 8'h11}, '{OP_SR_READ, 24'h0030ff, 8'hfc}};
  assign io_in = {io3, wp_n, io_oe[1] ? io_out[1] : 1'b1, mosi};
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (st_wr_p) st_wr <= 1'b1;
    if (st_ref_p) st_ref <= 1'b1;
    if (erase_p) {ek, erase_addr} <= {kind, mem_addr};
    if (prog_p) begin
      n_prog <= n_prog + 1;
      {pd, pa} <= {prog_dat, mem_addr[7:0]};
    end
  end
  sfpm_host i_host (.clk(clk), .miso(io_in[1]), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  sfpm_core i_dut (.clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(qe), .pause_restart_select(sel),
    .status_guard_bit(guard), .lock_bits(locks), .mem_addr(mem_addr),
    .mem_space(mem_space), .mem_rd_data(mem_addr[7:0] ^ {6'h00, mem_space}),
    .mem_prog(prog_p), .mem_prog_data(prog_dat), .mem_erase(erase_p), .erase_kind(kind),
    .status_wr(st_wr_p), .status_wr_data(st_dat), .status_wr_refused(st_ref_p),
    .write_enable_latch(wel_o), .paused(paused), .hw_reset_active(hw_rst));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic head(input logic [7:0] op, input logic [23:0] a, input logic adr);
    i_host.start();
    i_host.xfer(op, rx);
    for (int i = 2; i >= 0; i--) begin
      if (adr) i_host.xfer(a[8*i +: 8], rx);
    end
    if (op == OP_SFDP || op == OP_SR_READ) i_host.xfer(8'h00, rx);
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic adr,
                       input logic dat, input logic [7:0] d);
    head(op, a, adr);
    if (dat) i_host.xfer(d, rx);
    i_host.stop();
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    check(io_oe, 4'h0);
    foreach (rows[i]) begin
      frame(rows[i].op, rows[i].a, 1'b1, 1'b1, 8'h00);
      check(rx, rows[i].e);
    end
    wp_n = 1'b0;
    for (int q = 0; q < 2; q++) begin
      qe = q[0];
      {st_wr, st_ref} = 2'b00;
      frame(OP_WREN, 24'h0, 1'b0, 1'b0, 8'h00);
      frame(OP_WSTAT, 24'h0, 1'b0, 1'b1, 8'h3c);
      check({st_wr, st_ref}, q ? 2'b10 : 2'b01);
      check(st_dat, 8'h3c);
    end
    {qe, wp_n} = 2'b01;
    frame(OP_WREN, 24'h0, 1'b0, 1'b0, 8'h00);
    frame(OP_SERASE, 24'h123456, 1'b1, 1'b0, 8'h00);
    check({ek, erase_addr}, {ER_SECTOR, 21'h123000});
    frame(OP_WREN, 24'h0, 1'b0, 1'b0, 8'h00);
    frame(OP_BERASE, 24'h123456, 1'b1, 1'b0, 8'h00);
    check({ek, erase_addr}, {ER_BLOCK, 21'h120000});
    frame(OP_WREN, 24'h0, 1'b0, 1'b0, 8'h00);
    check(wel_o, 1'b1);
    frame(OP_PROG, 24'h000042, 1'b1, 1'b1, 8'h0f);
    check({pd, pa}, 16'h0242);
    check(wel_o, 1'b0);
    locks = 3'h1;
    frame(OP_WREN, 24'h0, 1'b0, 1'b0, 8'h00);
    frame(OP_SR_PROG, 24'h001005, 1'b1, 1'b1, 8'h00);
    check(n_prog, 1);
    frame(OP_WREN, 24'h0, 1'b0, 1'b0, 8'h00);
    frame(OP_SR_PROG, 24'h002007, 1'b1, 1'b1, 8'h00);
    check({pd, pa}, 16'h0007);
    frame(OP_WREN, 24'h0, 1'b0, 1'b0, 8'h00);
    frame(OP_SR_PROG, 24'h000003, 1'b1, 1'b1, 8'h00);
    check(n_prog, 2);
    io3 = 1'b0;
    repeat (6) @(posedge clk);
    check(paused, 1'b0);
    #1 io3 = 1'b1;
    head(OP_SFDP, 24'h0, 1'b1);
    i_host.xfer(8'h00, rx);
    io3 = 1'b0;
    repeat (6) @(posedge clk);
    check({paused, io_oe}, 5'h10);
    #1 i_host.xfer(8'h00, rx);
    io3 = 1'b1;
    repeat (4) @(posedge clk);
    #1 i_host.xfer(8'h00, rx);
    i_host.stop();
    check(rx, 8'h46);
    sel = 1'b1;
    head(OP_READ, 24'h000012, 1'b1);
    io3 = 1'b0;
    repeat (60) @(posedge clk);
    check(hw_rst, 1'b1);
    #1 io3 = 1'b1;
    i_host.xfer(8'h00, rx);
    i_host.stop();
    check(rx, 8'hff);
    wrap_up();
  end
  initial begin
    #500000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
